/* File: satp_pkg.sv */
package satp_pkg;
  localparam int unsigned SATP_WORD_BITS = 16;
  localparam int unsigned SATP_NUM_TX    = 3;
  localparam int unsigned SATP_NUM_SLOTS = 6;
  localparam int unsigned SATP_ADDR_BITS = 8;
  // Register byte offsets
  localparam logic [7:0] SATP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SATP_STATUS_OFS = 8'h04;
  localparam logic [7:0] SATP_COMMIT_OFS = 8'h08;
  localparam logic [7:0] SATP_DATA_OFS   = 8'h10;
  localparam logic [7:0] SATP_DATA_LAST  = 8'h24;
  // Control field positions
  localparam int unsigned SATP_CTRL_EN_LSB  = 0;
  localparam int unsigned SATP_CTRL_MASTER  = 3;
  localparam int unsigned SATP_CTRL_SOFTRST = 4;
  localparam int unsigned SATP_CTRL_DIV_LSB = 8;
  // Status field positions
  localparam int unsigned SATP_STAT_PEND = 0;
  localparam int unsigned SATP_STAT_RUN  = 1;
  // Values after reset
  localparam logic [2:0]  SATP_EN_RST  = 3'h0;
  localparam logic [7:0]  SATP_DIV_RST = 8'h03;
  localparam logic [15:0] SATP_WORD_RST = 16'h0000;
  // Last bit index of a word
  localparam logic [3:0]  SATP_BIT_LAST = 4'hF;
endpackage

/* File: satp_tx.sv */
`timescale 1ns/100ps
module satp_tx
  import satp_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Chip state
  input  wire logic        stop_state,
  // Bit clock pin
  input  wire logic        tx_bit_clock_i,
  output logic             tx_bit_clock_o,
  output logic             tx_bit_clock_oe,
  // Word select pin
  input  wire logic        tx_word_select_i,
  output logic             tx_word_select_o,
  output logic             tx_word_select_oe,
  // Serial data
  output logic             tx_data_out_a,
  output logic             tx_data_out_b,
  output logic             tx_data_out_c
);

  typedef struct packed {
    logic [2:0]       en;
    logic             master;
    logic             soft_rst;
    logic [7:0]       div;
    logic [5:0][15:0] stage;
    logic [5:0][15:0] xfer;
    logic             req;
    logic [1:0]       ack_sync;
    logic [7:0]       cnt;
    logic             bclk;
    logic             link_on;
    logic             clk_oe;
    logic             ws_oe;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } satp_p_t;

  typedef struct packed {
    logic [2:0]       en_s1;
    logic [2:0]       en_s2;
    logic             m_s1;
    logic             m_s2;
    logic [1:0]       req_s;
    logic             ack;
    logic [5:0][15:0] bank;
    logic [3:0]       bitc;
    logic             ws_gen;
    logic             ws_last;
    logic [2:0][15:0] sh;
    logic [2:0]       sdo;
    logic             ws_pin;
    logic             primed;
  } satp_l_t;

  satp_p_t p;
  satp_p_t next_p;
  satp_l_t l;
  satp_l_t next_l;
  logic    ws_cur;
  logic    word_start;
  logic    pend;

  // Data slot from address: {valid, index}
  function automatic logic [3:0] satp_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - SATP_DATA_OFS;
    if (a >= SATP_DATA_OFS && a <= SATP_DATA_LAST && a[1:0] == 2'h0) begin
      return {1'b1, d[4:2]};
    end
    return 4'h0;
  endfunction

  // Slot of a lane for one half of the frame
  function automatic logic [2:0] satp_lane(input int unsigned ch, input logic rt);
    return 3'(ch * 2) + {2'h0, rt};
  endfunction

  assign pend = p.req ^ p.ack_sync[1];

  // Register side
  always_comb begin
    logic [3:0] s;
    logic       done;
    logic       rd_ok;
    s     = satp_slot(paddr);
    done  = psel && penable && p.pready;
    rd_ok = 1'b1;
    next_p = p;
    next_p.ack_sync = {p.ack_sync[0], l.ack};
    next_p.pready   = 1'b0;
    if (psel && penable && !p.pready) begin
      next_p.pready  = 1'b1;
      next_p.prdata  = 32'h0000_0000;
      if (paddr == SATP_CTRL_OFS) begin
        next_p.prdata[SATP_CTRL_EN_LSB +: 3] = p.en;
        next_p.prdata[SATP_CTRL_MASTER]      = p.master;
        next_p.prdata[SATP_CTRL_SOFTRST]     = p.soft_rst;
        next_p.prdata[SATP_CTRL_DIV_LSB +: 8] = p.div;
      end else if (paddr == SATP_STATUS_OFS) begin
        next_p.prdata[SATP_STAT_PEND] = pend;
        next_p.prdata[SATP_STAT_RUN]  = p.link_on;
      end else if (paddr == SATP_COMMIT_OFS) begin
        rd_ok = pwrite;
      end else if (s[3]) begin
        next_p.prdata[15:0] = p.stage[s[2:0]];
      end else begin
        rd_ok = 1'b0;
      end
      next_p.pslverr = !rd_ok;
    end
    if (done && pwrite && !p.pslverr) begin
      if (paddr == SATP_CTRL_OFS) begin
        next_p.en       = pwdata[SATP_CTRL_EN_LSB +: 3];
        next_p.master   = pwdata[SATP_CTRL_MASTER];
        next_p.soft_rst = pwdata[SATP_CTRL_SOFTRST];
        next_p.div      = pwdata[SATP_CTRL_DIV_LSB +: 8];
      end else if (paddr == SATP_COMMIT_OFS && !pend) begin
        next_p.xfer = p.stage;
        next_p.req  = !p.req;
      end else if (s[3]) begin
        next_p.stage[s[2:0]] = pwdata[15:0];
      end
    end
    // Idle link takes its first words on its first left word
    if (!p.link_on) begin
      next_p.req = 1'b0;
    end
    // Port activity and pin ownership
    next_p.link_on = !p.soft_rst && !stop_state && (|p.en);
    next_p.clk_oe  = next_p.link_on && p.master;
    next_p.ws_oe   = next_p.link_on && p.master;
    // Master bit clock divider
    if (p.link_on && p.master) begin
      if (p.cnt >= p.div) begin
        next_p.cnt  = 8'h00;
        next_p.bclk = !p.bclk;
      end else begin
        next_p.cnt = p.cnt + 8'h01;
      end
    end else begin
      next_p.cnt  = 8'h00;
      next_p.bclk = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p          <= '0;
      p.en       <= SATP_EN_RST;
      p.div      <= SATP_DIV_RST;
    end else begin
      p <= next_p;
    end
  end

  // Link side, own clock and word select
  assign ws_cur     = l.m_s2 ? l.ws_gen : l.ws_pin;
  assign word_start = ws_cur != l.ws_last;

  always_comb begin
    logic [15:0] w;
    w = SATP_WORD_RST;
    next_l = l;
    next_l.en_s1 = p.en;
    next_l.en_s2 = l.en_s1;
    next_l.m_s1  = p.master;
    next_l.m_s2  = l.m_s1;
    next_l.req_s = {l.req_s[0], p.req};
    next_l.ws_last = ws_cur;
    next_l.ws_pin  = tx_word_select_i;
    if (l.m_s2) begin
      next_l.bitc = l.bitc + 4'h1;
      if (l.bitc == SATP_BIT_LAST) begin
        next_l.ws_gen = !l.ws_gen;
      end
    end
    if (word_start && !ws_cur && (l.req_s[1] != l.ack || !l.primed)) begin
      next_l.bank   = p.xfer;
      next_l.ack    = l.req_s[1];
      next_l.primed = 1'b1;
    end
    for (int i = 0; i < SATP_NUM_TX; i++) begin
      w = next_l.bank[satp_lane(i, ws_cur)];
      if (word_start) begin
        next_l.sh[i]  = {w[14:0], 1'b0};
        next_l.sdo[i] = w[15];
      end else begin
        next_l.sh[i]  = {l.sh[i][14:0], 1'b0};
        next_l.sdo[i] = l.sh[i][15];
      end
      if (!l.en_s2[i]) begin
        next_l.sdo[i] = 1'b1;
      end
    end
  end

  always_ff @(negedge tx_bit_clock_i or negedge p.link_on) begin
    if (!p.link_on) begin
      l     <= '0;
      l.sdo <= 3'h7;
    end else begin
      l <= next_l;
    end
  end

  assign pready            = p.pready;
  assign prdata            = p.prdata;
  assign pslverr           = p.pslverr;
  assign tx_bit_clock_o    = p.bclk;
  assign tx_bit_clock_oe   = p.clk_oe;
  assign tx_word_select_o  = l.ws_gen;
  assign tx_word_select_oe = p.ws_oe;
  assign tx_data_out_a     = l.sdo[0];
  assign tx_data_out_b     = l.sdo[1];
  assign tx_data_out_c     = l.sdo[2];

  // Checks
  sequence s_word_end;
    l.m_s2 && l.bitc == SATP_BIT_LAST;
  endsequence
  sequence s_idle;
    stop_state || p.soft_rst || p.en == 3'h0;
  endsequence
  sequence s_drive;
    !stop_state && !p.soft_rst && p.en != 3'h0 && p.master;
  endsequence

  chk_data_park: assert property (@(posedge pclk) disable iff (!presetn)
    !p.link_on |-> l.sdo == 3'h7) else $error("data not parked high");
  chk_stop_data: assert property (@(posedge pclk) disable iff (!presetn)
    stop_state |=> ##1 (tx_data_out_a && tx_data_out_b && tx_data_out_c))
    else $error("data not high in stop");
  chk_soft_data: assert property (@(posedge pclk) disable iff (!presetn)
    p.soft_rst |=> ##1 (tx_data_out_a && tx_data_out_b && tx_data_out_c))
    else $error("data not high in soft reset");
  chk_lane_park: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    !l.en_s2[2] |=> tx_data_out_c) else $error("disabled lane not high");

  chk_clk_own: assert property (@(posedge pclk) disable iff (!presetn)
    tx_bit_clock_oe |-> p.master && p.link_on) else $error("clock driven as slave");
  chk_clk_drive: assert property (@(posedge pclk) disable iff (!presetn)
    s_drive |=> tx_bit_clock_oe) else $error("master clock pin not driven");
  chk_clk_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    p.link_on && p.master && p.cnt >= p.div |=> $changed(tx_bit_clock_o))
    else $error("master clock stuck");
  chk_clk_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !p.link_on |=> !tx_bit_clock_o) else $error("clock not quiet when idle");
  chk_clk_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle |=> !tx_bit_clock_oe) else $error("clock pin not released");
  chk_stop_clk: assert property (@(posedge pclk) disable iff (!presetn)
    stop_state |=> !tx_bit_clock_oe) else $error("clock pin driven in stop");

  chk_ws_own: assert property (@(posedge pclk) disable iff (!presetn)
    !p.master |=> !tx_word_select_oe) else $error("word select driven as slave");
  chk_ws_drive: assert property (@(posedge pclk) disable iff (!presetn)
    s_drive |=> tx_word_select_oe) else $error("master word select not driven");
  chk_ws_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle |=> !tx_word_select_oe) else $error("word select not released");
  chk_stop_ws: assert property (@(posedge pclk) disable iff (!presetn)
    stop_state |=> !tx_word_select_oe) else $error("word select driven in stop");

  chk_ws_period: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    s_word_end |=> $changed(tx_word_select_o)) else $error("word length wrong");
  chk_ws_hold: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    l.m_s2 && l.bitc != SATP_BIT_LAST |=> $stable(tx_word_select_o))
    else $error("word select moved mid word");
  chk_ws_left: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    $changed(l.ack) |-> !ws_cur) else $error("samples not loaded on left word");
  chk_msb_first: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    word_start && l.en_s2[0] |=> tx_data_out_a == l.bank[satp_lane(0, $past(ws_cur))][15])
    else $error("word not started with msb");
  chk_slave_shift: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    !word_start && l.en_s2[1] |=> tx_data_out_b == $past(l.sh[1][15]))
    else $error("shift not on bit clock");
  chk_frame_load: assert property (@(negedge tx_bit_clock_i) disable iff (!p.link_on)
    $changed(l.ack) |-> $past(word_start && !ws_cur))
    else $error("samples swapped mid frame");

  chk_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!p.link_on) [*3] |-> !pend) else $error("commit left pending while idle");
  chk_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");
endmodule

/* File: satp_codec.sv */
`timescale 1ns/100ps
module satp_codec (
  // Pin levels
  input  wire logic             gen,
  input  wire logic             bclk_in,
  input  wire logic             ws_in,
  input  wire logic [2:0]       sd,
  // Slave side drive
  output logic                  clk_o,
  output logic                  ws_o,
  // Captured words
  output logic                  stb,
  output logic                  lr,
  output logic [2:0][15:0]      words
);
  logic [3:0]       gc;
  logic [4:0]       cnt;
  logic             ws_q;
  logic [2:0][15:0] sr, nx;
  // Clock runs only while gen is high, held low otherwise
  initial begin
    {clk_o, stb, ws_o, gc} = 7'h0;
    #3.3;
    forever #6 clk_o = gen ? ~clk_o : 1'b0;
  end
  always @(posedge clk_o or negedge gen) begin
    if (!gen) begin
      gc   <= 4'h0;
      ws_o <= 1'b0;
    end else begin
      gc <= gc + 4'h1;
      if (gc == 4'hF) ws_o <= ~ws_o;
    end
  end
  // Word closes where select changes
  always @(posedge bclk_in) begin
    for (int i = 0; i < 3; i++) nx[i] = {sr[i][14:0], sd[i]};
    sr   <= nx;
    ws_q <= ws_in;
    stb  <= 1'b0;
    cnt  <= cnt + 5'h1;
    if (ws_in != ws_q) begin
      cnt <= 5'h0;
      if (cnt == 5'hF) begin
        words <= nx;
        lr    <= ws_q;
        stb   <= 1'b1;
      end
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  import satp_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %0t %h %h", $time, g, e); end end
  logic pclk, presetn, psel, penable, pwrite, stop_state, gen, pready, pslverr;
  logic tx_bit_clock_o, tx_bit_clock_oe, tx_word_select_o, tx_word_select_oe;
  logic tx_data_out_a, tx_data_out_b, tx_data_out_c, p_clk, p_ws, stb, lr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [1:0]       flt;
  logic [2:0][15:0] words;
  logic [48:0]      exp_q[$];
  int               miscompares, checks, cycles, seed = 32'h945DBA4F;
  wire tx_bit_clock_i = tx_bit_clock_oe ? tx_bit_clock_o : gen ? p_clk : flt[0];
  wire tx_word_select_i = tx_word_select_oe ? tx_word_select_o : gen ? p_ws : flt[1];
  wire [4:0] park = {tx_data_out_a, tx_data_out_b, tx_data_out_c,
                     tx_bit_clock_oe, tx_word_select_oe};
  always #5 pclk = ~pclk;
  always @(posedge pclk) flt <= flt + 2'h1;
  satp_tx i_dut (.*);
  satp_codec i_codec (.gen, .bclk_in(tx_bit_clock_i), .ws_in(tx_word_select_i),
    .sd({tx_data_out_c, tx_data_out_b, tx_data_out_a}), .clk_o(p_clk), .ws_o(p_ws),
    .stb, .lr, .words);
  task automatic close_out();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic ee, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    `CHK(pslverr, ee)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic session(input logic m);
    logic [2:0]  en;
    logic [15:0] w [6];
    logic [31:0] c, r;
    en = 3'($random(seed));
    if (en == 3'h0) en = 3'h6;
    c = {16'h0, 6'h0, 2'($random(seed)), 4'h0, m, 3'h0};
    apb(1'b1, SATP_CTRL_OFS, c, 1'b0, r);
    for (int i = 0; i < 6; i++) begin
      w[i] = 16'($random(seed));
      apb(1'b1, SATP_DATA_OFS + 8'(4 * i), {16'hFFFF, w[i]}, 1'b0, r);
      apb(1'b0, SATP_DATA_OFS + 8'(4 * i), 32'h0, 1'b0, r);
      `CHK(r, {16'h0, w[i]})
    end
    apb(1'b1, SATP_COMMIT_OFS, 32'h0, 1'b0, r);
    gen <= !m;
    apb(1'b1, SATP_CTRL_OFS, c | 32'(en), 1'b0, r);
    do apb(1'b0, SATP_STATUS_OFS, 32'h0, 1'b0, r); while (r[SATP_STAT_PEND] !== 1'b0);
    repeat (2) @(posedge stb);
    for (int k = 0; k < 2; k++)
      exp_q.push_back({k[0], en[2] ? w[4+k] : 16'hFFFF, en[1] ? w[2+k] : 16'hFFFF,
                       en[0] ? w[k] : 16'hFFFF});
    wait (exp_q.size() == 0);
    `CHK(park[1:0], {m, m})
    @(posedge pclk);
    stop_state <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(park, 5'h1C)
    stop_state <= 1'b0;
    apb(1'b1, SATP_CTRL_OFS, c | 32'(en) | 32'h10, 1'b0, r);
    repeat (4) @(posedge pclk);
    `CHK(park, 5'h1C)
    gen <= 1'b0;
    apb(1'b1, SATP_CTRL_OFS, c, 1'b0, r);
    repeat (4) @(posedge pclk);
    `CHK(park, 5'h1C)
  endtask
  // Result watcher
  initial begin
    logic [48:0] n;
    forever begin
      @(posedge stb);
      #1;
      if (exp_q.size() > 0 && exp_q[0][48] === lr) begin
        n = exp_q.pop_front();
        `CHK({lr, words}, n)
      end
    end
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, stop_state, gen} = 7'h0;
    {paddr, pwdata, flt} = 42'h0;
    repeat (12) @(posedge pclk);
    `CHK(park, 5'h1C)
    presetn <= 1'b1;
    apb(1'b0, SATP_CTRL_OFS, 32'h0, 1'b0, q);
    `CHK(q, {16'h0, SATP_DIV_RST, 5'h0, SATP_EN_RST})
    apb(1'b0, 8'h40, 32'h0, 1'b1, q);
    `CHK(q, 32'h0)
    for (int i = 0; i < 4; i++) session(i[0]);
    close_out();
  end
endmodule
